//--- logic/irem_pkg.sv
// Constants for the infrared edge interval meter
package irem_pkg;

    // Clock and time base
    localparam int CLK_HZ  = 20_000_000;
    localparam int CLK_NS  = 1_000_000_000 / CLK_HZ;
    localparam int TICK_HZ = 12_500;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam logic [10:0] TICK_LAST = 11'(TICK_DIV - 1);

    // Spike filter minimum high times, least times round up
    localparam int FILT_SHORT_NS = 2_000;
    localparam int FILT_LONG_NS  = 160_000;
    localparam logic [11:0] FILT_SHORT_CYC =
        12'((FILT_SHORT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] FILT_LONG_CYC =
        12'((FILT_LONG_NS + CLK_NS - 1) / CLK_NS);

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_DATA = 8'h36;
    localparam logic [7:0] IDX_CTRL = 8'h37;
    localparam logic [7:0] IDX_STAT = 8'h38;
    localparam logic [7:0] ADDR_DATA = 8'(4 * IDX_DATA);
    localparam logic [7:0] ADDR_CTRL = 8'(4 * IDX_CTRL);
    localparam logic [7:0] ADDR_STAT = 8'(4 * IDX_STAT);

    // Control fields
    localparam int CTRL_ITE   = 4;
    localparam int CTRL_FILTER_WIDTH_SELECT = 3;
    localparam int CTRL_RISE  = 2;
    localparam int CTRL_FALL  = 1;
    localparam logic [7:0] CTRL_WMASK = 8'h1E;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // Status fields
    localparam int STAT_FLAG = 0;
    localparam int STAT_OVF  = 1;

    // Counter limits
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_PRE = 8'hFE;

endpackage

//--- logic/irem_spike_filter.sv
// Input synchroniser and high-pulse spike filter
module irem_spike_filter (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and width choice
    input  wire logic ir_input,
    input  wire logic long_sel,
    // Filtered level
    output logic      filt
);

    logic        s1_r;
    logic        s2_r;
    logic        filt_r;
    logic        filt_nxt;
    logic [11:0] run_r;
    logic [11:0] run_nxt;
    logic [11:0] limit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= ir_input;
            s2_r <= s1_r;
        end
    end

    always_comb begin
        limit = long_sel ? irem_pkg::FILT_LONG_CYC
                         : irem_pkg::FILT_SHORT_CYC;
        run_nxt = 12'h000;
        filt_nxt = 1'b0;
        if (s2_r) begin
            // Saturate so a long high level never wraps
            run_nxt = (run_r == 12'hFFF) ? run_r : run_r + 12'h001;
            if (filt_r || run_r >= limit - 12'h001)
                filt_nxt = 1'b1;
        end
        // A low level passes at once, whatever its length
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r  <= 12'h000;
            filt_r <= 1'b0;
        end else begin
            run_r  <= run_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign filt = filt_r;

    a_filter_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        !s2_r |=> !filt_r)
        else $error("low level not passed");

    a_filter_width: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(filt_r) |-> $past(run_r) >= $past(limit) - 12'h001)
        else $error("short high pulse passed");

endmodule

//--- logic/irem_top.sv
// Infrared edge interval meter with APB register access
module irem_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Receiver pin
    input  wire logic        ir_input,
    // Interrupt request
    output logic             irq
);

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // Filtered and synchronised input
    logic        filt;
    logic        filt_d_r;

    // Time base and interval counter
    logic [10:0] div_r;
    logic [10:0] div_nxt;
    logic        tick;
    logic [7:0]  cnt_r;
    logic [7:0]  cnt_nxt;

    // Registers and flags
    logic [7:0]  data_r;
    logic [7:0]  data_nxt;
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic        flag_r;
    logic        flag_nxt;
    logic        ovf_r;
    logic        ovf_nxt;
    logic        irq_r;
    logic        irq_nxt;

    // Bus answer
    logic        pready_r;
    logic        pready_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;

    // Event terms
    logic        acc;
    logic        mapped;
    logic        wr_data;
    logic        wr_ctrl;
    logic        rise;
    logic        fall;
    logic        sel_edge;
    logic        edge_hit;
    logic        sat_hit;

    irem_spike_filter u_filter (
        .pclk     (pclk),
        .presetn  (presetn),
        .ir_input (ir_input),
        .long_sel (ctrl_r[irem_pkg::CTRL_FILTER_WIDTH_SELECT]),
        .filt     (filt)
    );

    // Edge detection on the clean level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            filt_d_r <= 1'b0;
        else
            filt_d_r <= filt;
    end

    always_comb begin
        rise = filt & ~filt_d_r;
        fall = ~filt & filt_d_r;
        sel_edge = (rise & ctrl_r[irem_pkg::CTRL_RISE])
                 | (fall & ctrl_r[irem_pkg::CTRL_FALL]);
    end

    // Bus decode; writes take effect on the edge that samples pready
    always_comb begin
        acc = psel & penable & pready_r;
        mapped = hit(paddr, irem_pkg::ADDR_DATA)
               | hit(paddr, irem_pkg::ADDR_CTRL)
               | hit(paddr, irem_pkg::ADDR_STAT);
        wr_data = acc & pwrite & hit(paddr, irem_pkg::ADDR_DATA);
        wr_ctrl = acc & pwrite & hit(paddr, irem_pkg::ADDR_CTRL);
    end

    // Time base: free running divider
    always_comb begin
        tick = (div_r == irem_pkg::TICK_LAST);
        div_nxt = tick ? 11'h000 : div_r + 11'h001;
    end

    // Measurement: edges are ignored while overflow is pending
    always_comb begin
        edge_hit = sel_edge & ~ovf_r;
        sat_hit = tick & ~ovf_r & ~edge_hit
                & (cnt_r == irem_pkg::CNT_PRE);
        cnt_nxt = cnt_r;
        data_nxt = data_r;
        flag_nxt = flag_r;
        ovf_nxt = ovf_r;
        // Software write stores a value and clears both flags
        if (wr_data) begin
            data_nxt = pwdata[7:0];
            flag_nxt = 1'b0;
            ovf_nxt = 1'b0;
            if (ovf_r)
                cnt_nxt = 8'h00;
        end
        // Hardware events win over a clear in the same cycle
        if (edge_hit) begin
            data_nxt = cnt_r;
            flag_nxt = 1'b1;
            cnt_nxt = 8'h00;
        end else if (sat_hit) begin
            cnt_nxt = irem_pkg::CNT_MAX;
            data_nxt = irem_pkg::CNT_MAX;
            flag_nxt = 1'b1;
            ovf_nxt = 1'b1;
        end else if (tick && !ovf_r && !(wr_data && ovf_r)) begin
            cnt_nxt = cnt_r + 8'h01;
        end
        if (ovf_r && !wr_data)
            data_nxt = data_r;
    end

    // Control register: reserved bits forced low
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
            ctrl_nxt = pwdata[7:0] & irem_pkg::CTRL_WMASK;
        irq_nxt = flag_nxt & ctrl_nxt[irem_pkg::CTRL_ITE];
    end

    // APB answer one cycle into the access phase
    always_comb begin
        pready_nxt = psel & penable & ~pready_r;
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (pready_nxt) begin
            pslverr_nxt = ~mapped;
            if (!pwrite) begin
                if (hit(paddr, irem_pkg::ADDR_DATA))
                    prdata_nxt = {24'h00_0000, data_r};
                else if (hit(paddr, irem_pkg::ADDR_CTRL))
                    prdata_nxt = {24'h00_0000, ctrl_r};
                else if (hit(paddr, irem_pkg::ADDR_STAT))
                    prdata_nxt = {30'h0, ovf_r, flag_r};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r     <= 11'h000;
            cnt_r     <= 8'h00;
            data_r    <= irem_pkg::DATA_RST;
            ctrl_r    <= irem_pkg::CTRL_RST;
            flag_r    <= 1'b0;
            ovf_r     <= 1'b0;
            irq_r     <= 1'b0;
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            div_r     <= div_nxt;
            cnt_r     <= cnt_nxt;
            data_r    <= data_nxt;
            ctrl_r    <= ctrl_nxt;
            flag_r    <= flag_nxt;
            ovf_r     <= ovf_nxt;
            irq_r     <= irq_nxt;
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_edge_latch: assert property (
        edge_hit |=> data_r == $past(cnt_r) && flag_r && cnt_r == 8'h00)
        else $error("edge did not latch count");

    a_rise_select: assert property (
        rise && ctrl_r[irem_pkg::CTRL_RISE] && !ovf_r |=> flag_r)
        else $error("selected rising edge missed");

    a_fall_select: assert property (
        fall && ctrl_r[irem_pkg::CTRL_FALL] && !ovf_r |=> flag_r)
        else $error("selected falling edge missed");

    a_no_overrun: assert property (
        edge_hit && flag_r |=> flag_r && !ovf_r)
        else $error("unread value raised overflow");

    a_sat_latch: assert property (
        sat_hit |=> data_r == 8'hFF && flag_r && ovf_r)
        else $error("saturation did not latch");

    a_ovf_value: assert property (
        ovf_r |-> data_r == irem_pkg::CNT_MAX && cnt_r == irem_pkg::CNT_MAX)
        else $error("overflow without saturated value");

    a_ovf_freeze: assert property (
        ovf_r && !wr_data |=> $stable(data_r) && cnt_r == 8'hFF)
        else $error("data or count moved during overflow");

    a_ovf_restart: assert property (
        ovf_r && wr_data |=> !ovf_r && !flag_r && cnt_r == 8'h00)
        else $error("counter did not restart after clear");

    a_write_clears: assert property (
        wr_data && !edge_hit && !sat_hit |=> !flag_r && !ovf_r)
        else $error("data write did not clear flags");

    a_data_write: assert property (
        wr_data && !edge_hit && !sat_hit |=> data_r == $past(pwdata[7:0]))
        else $error("data write lost");

    a_ctrl_write: assert property (
        wr_ctrl |=> ctrl_r == ($past(pwdata[7:0]) & irem_pkg::CTRL_WMASK))
        else $error("control write lost");

    a_ctrl_reserved: assert property (
        (ctrl_r & ~irem_pkg::CTRL_WMASK) == 8'h00)
        else $error("reserved control bit set");

    a_irq_gate: assert property (
        irq |-> flag_r && ctrl_r[irem_pkg::CTRL_ITE])
        else $error("interrupt without enabled flag");

    a_irq_raise: assert property (
        flag_r && ctrl_r[irem_pkg::CTRL_ITE] |-> irq)
        else $error("enabled flag without interrupt");

    a_no_edge_mode: assert property (
        ctrl_r[2:1] == 2'b00 && !sat_hit && !wr_data |=> $stable(data_r))
        else $error("latch with no edge selected");

    a_tick_spacing: assert property (
        tick |=> !tick [*8])
        else $error("tick period too short");

    a_tick_divide: assert property (
        div_r <= irem_pkg::TICK_LAST)
        else $error("divider ran past its end");

    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    a_flag_set_wins: assert property (
        edge_hit && wr_data |=> flag_r)
        else $error("flag clear beat an event");

    c_edge_latch: cover property (edge_hit ##1 irq);
    c_overflow: cover property (sat_hit ##1 ovf_r);
    c_clear_ovf: cover property (ovf_r ##0 wr_data ##1 !ovf_r);
    c_overwrite: cover property (edge_hit && flag_r);
    c_event_clear: cover property (edge_hit && wr_data);

endmodule

//--- verif/irem_rx_model.sv
// Demodulated infrared receiver model driving the meter's input pin
module irem_rx_model (
    // Clock
    input  wire logic pclk,
    // Receiver output, idle low, high while a burst is seen
    output logic      ir_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ir_out = 1'b0;
    // Hold a level for n cycles, changed just after an edge
    task automatic hold(input logic lvl, input int n);
        ir_out <= lvl;
        repeat (n) @(posedge pclk);
    endtask
endmodule

//--- verif/test_ir_edge_interval_meter.sv
// Self-checking bench for the infrared edge interval meter
module test_ir_edge_interval_meter;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ir_input;
    logic        irq;
    int          n_errors = 0;
    int          total_checks = 0;
    logic [31:0] q;
    logic        e;
    time         t0;
    time         t1;
    localparam int TICK_NS = irem_pkg::TICK_DIV * irem_pkg::CLK_NS;
    always #25 pclk = ~pclk;
    irem_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ir_input(ir_input), .irq(irq));
    irem_rx_model rx_u (.pclk(pclk), .ir_out(ir_input));
    task automatic end_of_test();
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Prescaler runs freely, so a count may be one tick either way
    task automatic chk_near(input logic [31:0] got, input logic [31:0] ex);
        total_checks++;
        if ((got + 1 >= ex && got <= ex + 1) !== 1'b1) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i == 20) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic st();
        apb(1'b0, irem_pkg::ADDR_STAT, 32'h0);
    endtask
    // Clear pending flags, send one high pulse, then read status
    task automatic pulse(input int w);
        apb(1'b1, irem_pkg::ADDR_DATA, 32'h0);
        rx_u.hold(1'b1, w);
        rx_u.hold(1'b0, 100);
        st();
    endtask
    task automatic reg_tests();
        apb(1'b0, irem_pkg::ADDR_DATA, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, irem_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, irem_pkg::ADDR_CTRL, 32'hFF);
        apb(1'b0, irem_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h1E);
        apb(1'b0, 8'h00, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic edge_tests();
        apb(1'b1, irem_pkg::ADDR_CTRL, 32'h14);
        t0 = $time;
        rx_u.hold(1'b1, 100);
        apb(1'b1, irem_pkg::ADDR_DATA, 32'h0);
        rx_u.hold(1'b1, 3100);
        rx_u.hold(1'b0, 3200);
        st();
        chk(q, 32'h0);
        t1 = $time;
        rx_u.hold(1'b1, 100);
        st();
        chk(q, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, irem_pkg::ADDR_DATA, 32'h0);
        chk_near(q, 32'((t1 - t0) / TICK_NS));
        rx_u.hold(1'b1, 1500);
        rx_u.hold(1'b0, 1700);
        t0 = $time;
        rx_u.hold(1'b1, 100);
        st();
        chk(q, 32'h1);
        apb(1'b0, irem_pkg::ADDR_DATA, 32'h0);
        chk_near(q, 32'((t0 - t1) / TICK_NS));
        apb(1'b1, irem_pkg::ADDR_DATA, 32'h5A);
        st();
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, irem_pkg::ADDR_DATA, 32'h0);
        chk(q, 32'h5A);
    endtask
    task automatic quiet_tests();
        apb(1'b1, irem_pkg::ADDR_CTRL, 32'h02);
        rx_u.hold(1'b1, 100);
        apb(1'b1, irem_pkg::ADDR_DATA, 32'h0);
        rx_u.hold(1'b0, 3);
        rx_u.hold(1'b1, 100);
        st();
        chk(q, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // No edge selected: only saturation may latch
        apb(1'b1, irem_pkg::ADDR_CTRL, 32'h10);
        pulse(60);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic filter_tests();
        apb(1'b1, irem_pkg::ADDR_CTRL, 32'h06);
        rx_u.hold(1'b0, 100);
        pulse(30);
        chk(q, 32'h0);
        pulse(60);
        chk(q, 32'h1);
        apb(1'b1, irem_pkg::ADDR_CTRL, 32'h0E);
        pulse(3000);
        chk(q, 32'h0);
        pulse(3300);
        chk(q, 32'h1);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reg_tests();
        edge_tests();
        quiet_tests();
        filter_tests();
        end_of_test();
    end
endmodule
